// ---- hw/atu_pkg.sv ----
package atu_pkg;
  // address widths
  localparam int EA_W = 32;
  localparam int PA_W = 32;
  localparam int VSID_W = 24;
  localparam int PIDX_W = 16;
  localparam int VA_W = VSID_W + PIDX_W + 12;
  // 4 Kbyte pages and 256 Mbyte segments
  localparam int PAGE_SHIFT = 12;
  localparam int SEG_SHIFT = 28;
  // buffer geometry
  localparam int TLB_ENTRIES = 64;
  localparam int TLB_WAYS = 2;
  localparam int BAT_ENTRIES = 4;
  // blocks from 128 Kbytes (shift 17) to 256 Mbytes (11 mask bits)
  localparam int BLK_SHIFT = 17;
  localparam int BL_W = 11;
  // page entry group: eight 8-byte entries, 64 bytes
  localparam int PTE_BYTES = 8;
  localparam int PAGE_ENTRY_GROUP_PTES = 8;
  localparam int PAGE_ENTRY_GROUP_SHIFT = 6;
  localparam int TABLE_MASK_W = 9;
  // exception vector offsets
  localparam logic [15:0] VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS = 16'h1000;
  localparam logic [15:0] VEC_DLOAD_MISS = 16'h1100;
  localparam logic [15:0] VEC_DSTORE_MISS = 16'h1200;
  localparam logic [15:0] VEC_DPROT = 16'h0300;
  localparam logic [15:0] VEC_IPROT = 16'h0400;

  // one access request
  typedef struct packed {
    logic valid;
    logic store;
    logic [EA_W-1:0] ea;
  } xreq_t;

  // translation result
  typedef struct packed {
    logic valid;
    logic ok;
    logic blk;
    logic [PA_W-1:0] pa;
  } xresp_t;

  // exception with table search assistance
  typedef struct packed {
    logic valid;
    logic [15:0] vector;
    logic [EA_W-1:0] ea;
    logic [PA_W-1:0] page_entry_group_addr;
    logic [VSID_W-1:0] vsid;
    logic [5:0] api;
    logic way;
  } xexc_t;

  typedef struct packed {
    xresp_t r;
    xexc_t e;
  } xout_t;

  // cached page table entry
  typedef struct packed {
    logic valid;
    logic [VSID_W-1:0] vsid;
    logic [PIDX_W-1:0] pidx;
    logic [19:0] rpn;
    logic [1:0] pp;
    logic changed;
  } pte_t;

  // block translation array entry
  typedef struct packed {
    logic [14:0] bepi;
    logic [BL_W-1:0] bl;
    logic vs;
    logic vp;
    logic [14:0] brpn;
    logic [1:0] pp;
  } bat_t;

  // segment register
  typedef struct packed {
    logic [VSID_W-1:0] vsid;
    logic ks;
    logic kp;
  } seg_t;
endpackage

// ---- hw/translation_buffer.sv ----
`timescale 1ns/1ns
module translation_buffer import atu_pkg::*; #(
  parameter int SETS = 32,
  parameter int WAYS = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // lookup
  input wire logic [VSID_W-1:0] vsid_in,
  input wire logic [PIDX_W-1:0] pidx_in,
  input wire logic touch_in,
  // maintenance
  input wire logic wr_in,
  input wire logic wr_way_in,
  input wire pte_t wr_entry_in,
  input wire logic inv_in,
  input wire logic [PIDX_W-1:0] inv_pidx_in,
  // lookup result
  output logic hit_out,
  output pte_t entry_out,
  output logic lru_out
);
  localparam int IW = $clog2(SETS);

  // refuse geometries that the two-way compare and set indexing cannot serve
  if (WAYS != 2 || SETS < 2 || (1 << IW) != SETS || IW >= PIDX_W)
  begin : g_bad_geometry
    $error("translation_buffer: unsupported geometry");
  end

  pte_t mem_q [SETS][WAYS]; // entries
  pte_t mem_d [SETS][WAYS];
  logic [SETS-1:0] lru_q; // way to replace next, per set
  logic [SETS-1:0] lru_d;
  logic hit_way; // way that matched
  logic [IW-1:0] set_idx;

  assign set_idx = pidx_in[IW-1:0];

  // two-way compare on virtual segment id and page index
  always_comb
  begin
    hit_out = 1'b0;
    entry_out = '0;
    hit_way = 1'b0;
    for (int w = 0; w < WAYS; w++)
    begin
      if (mem_q[set_idx][w].valid && mem_q[set_idx][w].vsid == vsid_in &&
          mem_q[set_idx][w].pidx == pidx_in)
      begin
        hit_out = 1'b1;
        entry_out = mem_q[set_idx][w];
        hit_way = w[0];
      end
    end
    lru_out = lru_q[set_idx];
  end

  // next contents: selective invalidate, then a load wins for the same set
  always_comb
  begin
    mem_d = mem_q;
    lru_d = lru_q;
    if (touch_in && hit_out)
      lru_d[set_idx] = ~hit_way;
    if (inv_in)
    begin
      for (int w = 0; w < WAYS; w++)
        mem_d[inv_pidx_in[IW-1:0]][w].valid = 1'b0;
    end
    if (wr_in)
    begin
      mem_d[wr_entry_in.pidx[IW-1:0]][wr_way_in] = wr_entry_in;
      lru_d[wr_entry_in.pidx[IW-1:0]] = ~wr_way_in;
    end
  end

  // reset clears whole entries and all replacement bits
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      for (int s = 0; s < SETS; s++)
        for (int w = 0; w < WAYS; w++)
          mem_q[s][w] <= '0;
      lru_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      lru_q <= lru_d;
    end
  end
endmodule // translation_buffer

// ---- hw/address_translation_unit.sv ----
`timescale 1ns/1ns
// Behaviour
// - translate addresses, check block and page permissions
// - translate fetches and load/store data accesses
// - each class translates only when enabled
// - groups of eight 8-byte entries, 64 bytes
// - 4 Kbyte pages, 256 Mbyte segments
// - blocks from 128 Kbytes to 256 Mbytes
// - 52-bit virtual address, hashed table, 32-bit result
// - misses and violations raise exceptions
// - buffer lookup parallel to cache, no delay
// - two 64-entry two-way translation buffers
// - hardware assist for software table search
// - supervisor invalidates buffer entries selectively
// - four-entry block arrays per class, software loaded
// - buffers do not track memory page tables
// - load/store: translate stage, then cache stage
// - fetch miss raises vector 01000
// - load miss raises vector 01100
// - store miss or unset changed bit: 01200
module address_translation_unit import atu_pkg::*; #(
  parameter int TLB_SETS = TLB_ENTRIES / TLB_WAYS
) (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // machine state
  input wire logic INSTR_TRANSLATE_ENABLE_IN,
  input wire logic DATA_TRANSLATE_ENABLE_IN,
  input wire logic SUPERVISOR_IN,
  // segment register load
  input wire logic SEG_WR_IN,
  input wire logic [3:0] SEG_IDX_IN,
  input wire seg_t SEG_DATA_IN,
  // page table location
  input wire logic [15:0] TABLE_BASE_IN,
  input wire logic [TABLE_MASK_W-1:0] TABLE_MASK_IN,
  // translation buffer maintenance
  input wire logic TLB_WR_IN,
  input wire logic TLB_WR_DATA_IN,
  input wire logic TLB_WR_WAY_IN,
  input wire pte_t TLB_WR_ENTRY_IN,
  input wire logic TLB_INV_IN,
  input wire logic [EA_W-1:0] TLB_INV_EA_IN,
  // block array load
  input wire logic BAT_WR_IN,
  input wire logic BAT_WR_DATA_IN,
  input wire logic [1:0] BAT_WR_IDX_IN,
  input wire bat_t BAT_WR_ENTRY_IN,
  // access requests
  input wire xreq_t FETCH_REQ_IN,
  input wire xreq_t LSU_REQ_IN,
  // results
  output xresp_t FETCH_RESP_OUT,
  output xresp_t LSU_RESP_OUT,
  output xexc_t FETCH_EXC_OUT,
  output xexc_t LSU_EXC_OUT
);
  // buffers are sized from the set count, so it must cover the entries exactly
  if (TLB_SETS * TLB_WAYS != TLB_ENTRIES)
  begin : g_bad_sets
    $error("address_translation_unit: set count does not match entries");
  end

  seg_t seg_q [16]; // segment registers
  seg_t seg_d [16];
  bat_t ibat_q [BAT_ENTRIES]; // instruction block array
  bat_t ibat_d [BAT_ENTRIES];
  bat_t dbat_q [BAT_ENTRIES]; // data block array
  bat_t dbat_d [BAT_ENTRIES];
  xout_t fetch_x; // stage-one results
  xout_t lsu_x;
  xout_t fetch_q;
  xout_t lsu_q;
  seg_t fseg;
  seg_t dseg;
  logic ihit;
  logic dhit;
  logic ilru;
  logic dlru;
  pte_t ient;
  pte_t dent;
  logic inv_ok;

  // one translation, shared by both access classes
  function automatic xout_t xlate(input xreq_t rq, input logic en, input logic instr,
                                  input logic sup, input seg_t sg, input bat_t bats [BAT_ENTRIES],
                                  input logic thit, input pte_t te, input logic lru,
                                  input logic [15:0] base, input logic [TABLE_MASK_W-1:0] mask);
    xout_t o;
    logic bhit;
    logic key;
    logic rd_ok;
    logic wr_ok;
    logic st;
    logic [14:0] bm;
    logic [18:0] hash;
    o = '0;
    bhit = 1'b0;
    key = sup ? sg.ks : sg.kp;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    st = rq.store & ~instr;
    bm = '0;
    hash = sg.vsid[18:0] ^ {3'h0, rq.ea[SEG_SHIFT-1:PAGE_SHIFT]};
    o.r.valid = rq.valid;
    o.r.pa = rq.ea; // untranslated when disabled
    o.r.ok = rq.valid;
    if (rq.valid && en)
    begin
      o.r.ok = 1'b0;
      // first matching block entry wins, before the page result
      for (int i = 0; i < BAT_ENTRIES; i++)
      begin
        bm = {4'h0, bats[i].bl};
        if (!bhit && (sup ? bats[i].vs : bats[i].vp) &&
            (rq.ea[EA_W-1:BLK_SHIFT] & ~bm) == (bats[i].bepi & ~bm))
        begin
          bhit = 1'b1;
          o.r.pa = {bats[i].brpn | (rq.ea[EA_W-1:BLK_SHIFT] & bm),
                    rq.ea[BLK_SHIFT-1:0]};
          rd_ok = |bats[i].pp; // block protection
          wr_ok = bats[i].pp[1];
        end
      end
      if (!bhit && thit)
      begin
        o.r.pa = {te.rpn, rq.ea[PAGE_SHIFT-1:0]};
        rd_ok = !(key && te.pp == 2'b00); // page protection
        wr_ok = (te.pp == 2'b10) || (!key && !te.pp[1]);
      end
      o.r.blk = bhit;
      o.e.valid = 1'b1;
      // exception selection
      if (!bhit && !thit)
        o.e.vector = instr ? VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS : (st ? VEC_DSTORE_MISS : VEC_DLOAD_MISS);
      else if (!rd_ok || (st && !wr_ok))
        o.e.vector = instr ? VEC_IPROT : VEC_DPROT;
      else if (!bhit && st && !te.changed)
        o.e.vector = VEC_DSTORE_MISS; // changed bit needs software
      else
        o.e.valid = 1'b0;
      o.r.ok = !o.e.valid;
      if (o.e.valid)
      begin
        // primary group address for the search handler
        o.e.ea = rq.ea;
        o.e.vsid = sg.vsid;
        o.e.api = rq.ea[SEG_SHIFT-1:22];
        o.e.way = lru;
        o.e.page_entry_group_addr = {base[15:9], base[8:0] | (hash[18:10] & mask), hash[9:0],
                         {PAGE_ENTRY_GROUP_SHIFT{1'b0}}};
      end
    end
    return o;
  endfunction

  assign fseg = seg_q[FETCH_REQ_IN.ea[EA_W-1:SEG_SHIFT]];
  assign dseg = seg_q[LSU_REQ_IN.ea[EA_W-1:SEG_SHIFT]];
  assign inv_ok = TLB_INV_IN & SUPERVISOR_IN;

  // separate buffers per class; contents change only by explicit loads and invalidates
  translation_buffer #(.SETS(TLB_SETS), .WAYS(TLB_WAYS)) u_instruction_translation_buffer (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .vsid_in(fseg.vsid),
    .pidx_in(FETCH_REQ_IN.ea[SEG_SHIFT-1:PAGE_SHIFT]),
    .touch_in(FETCH_REQ_IN.valid & INSTR_TRANSLATE_ENABLE_IN),
    .wr_in(TLB_WR_IN & ~TLB_WR_DATA_IN),
    .wr_way_in(TLB_WR_WAY_IN),
    .wr_entry_in(TLB_WR_ENTRY_IN),
    .inv_in(inv_ok),
    .inv_pidx_in(TLB_INV_EA_IN[SEG_SHIFT-1:PAGE_SHIFT]),
    .hit_out(ihit),
    .entry_out(ient),
    .lru_out(ilru)
  );

  translation_buffer #(.SETS(TLB_SETS), .WAYS(TLB_WAYS)) u_data_translation_buffer (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .vsid_in(dseg.vsid),
    .pidx_in(LSU_REQ_IN.ea[SEG_SHIFT-1:PAGE_SHIFT]),
    .touch_in(LSU_REQ_IN.valid & DATA_TRANSLATE_ENABLE_IN),
    .wr_in(TLB_WR_IN & TLB_WR_DATA_IN),
    .wr_way_in(TLB_WR_WAY_IN),
    .wr_entry_in(TLB_WR_ENTRY_IN),
    .inv_in(inv_ok),
    .inv_pidx_in(TLB_INV_EA_IN[SEG_SHIFT-1:PAGE_SHIFT]),
    .hit_out(dhit),
    .entry_out(dent),
    .lru_out(dlru)
  );

  // stage one: lookup runs in the same cycle as the cache index
  always_comb
  begin
    fetch_x = xlate(FETCH_REQ_IN, INSTR_TRANSLATE_ENABLE_IN, 1'b1, SUPERVISOR_IN, fseg,
                    ibat_q, ihit, ient, ilru, TABLE_BASE_IN, TABLE_MASK_IN);
    lsu_x = xlate(LSU_REQ_IN, DATA_TRANSLATE_ENABLE_IN, 1'b0, SUPERVISOR_IN, dseg,
                  dbat_q, dhit, dent, dlru, TABLE_BASE_IN, TABLE_MASK_IN);
  end

  // software-loaded segment and block state
  always_comb
  begin
    seg_d = seg_q;
    ibat_d = ibat_q;
    dbat_d = dbat_q;
    if (SEG_WR_IN)
      seg_d[SEG_IDX_IN] = SEG_DATA_IN;
    if (BAT_WR_IN && BAT_WR_DATA_IN)
      dbat_d[BAT_WR_IDX_IN] = BAT_WR_ENTRY_IN;
    else if (BAT_WR_IN)
      ibat_d[BAT_WR_IDX_IN] = BAT_WR_ENTRY_IN;
  end

  // register state and results; cleared block entries are invalid
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i < 16; i++)
        seg_q[i] <= '0;
      for (int i = 0; i < BAT_ENTRIES; i++)
      begin
        ibat_q[i] <= '0;
        dbat_q[i] <= '0;
      end
      fetch_q <= '0;
      lsu_q <= '0;
    end
    else
    begin
      seg_q <= seg_d;
      ibat_q <= ibat_d;
      dbat_q <= dbat_d;
      fetch_q <= fetch_x;
      lsu_q <= lsu_x;
    end
  end

  assign FETCH_RESP_OUT = fetch_q.r;
  assign FETCH_EXC_OUT = fetch_q.e;
  assign LSU_RESP_OUT = lsu_q.r;
  assign LSU_EXC_OUT = lsu_q.e;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  a_fetch_one_cycle: assert property (FETCH_REQ_IN.valid |=> FETCH_RESP_OUT.valid)
    else $error("fetch result not one cycle after request");
  a_lsu_stage_two: assert property (!LSU_REQ_IN.valid |=> !LSU_RESP_OUT.valid)
    else $error("load/store result without request");
  a_real_mode: assert property (LSU_REQ_IN.valid && !DATA_TRANSLATE_ENABLE_IN |=>
      LSU_RESP_OUT.ok && !LSU_EXC_OUT.valid && LSU_RESP_OUT.pa == $past(LSU_REQ_IN.ea))
    else $error("untranslated access altered");
  a_fetch_vector: assert property (FETCH_EXC_OUT.valid |->
      FETCH_EXC_OUT.vector == VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS || FETCH_EXC_OUT.vector == VEC_IPROT)
    else $error("bad fetch exception vector");
  a_load_vector: assert property (LSU_EXC_OUT.valid && LSU_EXC_OUT.vector == VEC_DLOAD_MISS
      |-> !$past(LSU_REQ_IN.store))
    else $error("load miss vector on a store");
  a_store_vector: assert property (LSU_EXC_OUT.valid && LSU_EXC_OUT.vector == VEC_DSTORE_MISS
      |-> $past(LSU_REQ_IN.store))
    else $error("store miss vector on a load");
  a_exc_blocks_ok: assert property (LSU_EXC_OUT.valid |-> !LSU_RESP_OUT.ok)
    else $error("access allowed despite exception");
  a_group_align: assert property (LSU_EXC_OUT.valid |->
      LSU_EXC_OUT.page_entry_group_addr[5:0] == 6'h00 && LSU_EXC_OUT.api == $past(LSU_REQ_IN.ea[27:22]))
    else $error("search assist fields wrong");
  a_page_offset: assert property (LSU_RESP_OUT.ok |->
      LSU_RESP_OUT.pa[11:0] == $past(LSU_REQ_IN.ea[11:0]))
    else $error("page offset altered");
  a_block_offset: assert property (LSU_RESP_OUT.blk |->
      LSU_RESP_OUT.pa[16:0] == $past(LSU_REQ_IN.ea[16:0]))
    else $error("block offset altered");
endmodule // address_translation_unit

// ---- test/access_unit_model.sv ----
`timescale 1ns/1ns
// requester model standing in for the fetch unit or the load/store unit
module access_unit_model import atu_pkg::*; (
  // clock
  input wire logic clk_in,
  // stimulus from the bench
  input wire logic go_in,
  input wire logic store_in,
  input wire logic [EA_W-1:0] ea_in,
  // request towards the translation unit
  output xreq_t req_out,
  // answer path back
  input wire xresp_t resp_in,
  input wire xexc_t exc_in,
  output xresp_t resp_out,
  output xexc_t exc_out
);
  logic pend_q; // a request was taken at the last edge
  // an idle address shows the inverse, so a stale value never passes as a live one
  assign req_out = '{valid: go_in, store: store_in, ea: go_in ? ea_in : ~ea_in};
  // capture exactly one cycle after the taking edge, no later
  always_ff @(posedge clk_in)
  begin
    pend_q <= go_in;
    if (pend_q)
    begin
      resp_out <= resp_in;
      exc_out <= exc_in;
    end
  end
endmodule // access_unit_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
module tb_top import atu_pkg::*;;
  localparam logic [31:0] EA = 32'h1234_5678; // access address under test
  localparam logic [23:0] VSID = 24'h00abcd; // segment id of that address
  localparam logic [19:0] RPN = 20'h9abcd; // page frame for that address
  localparam logic [31:0] EA2 = EA + 32'h0002_0000; // same set and segment, next block
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ite = 1'b0, dte = 1'b0, sup = 1'b0;
  logic seg_wr = 1'b0;
  seg_t seg_data = '0;
  logic [15:0] base = 16'h0200; // aligned to the table size
  logic [8:0] mask = 9'h1ff;
  logic tlb_wr = 1'b0, tlb_inv = 1'b0, bat_wr = 1'b0;
  logic tlb_dsel = 1'b1, tlb_way = 1'b0, bat_dsel = 1'b1; // which buffer, way and array to load
  logic [1:0] bat_idx = 2'h0;
  pte_t tlb_e = '0;
  bat_t bat_e = '0;
  logic go [2] = '{1'b0, 1'b0};
  logic st [2] = '{1'b0, 1'b0};
  logic [31:0] ea [2] = '{32'h0, 32'h0};
  xreq_t req [2];
  xresp_t resp [2], got_r [2];
  xexc_t exc [2], got_e [2];
  int bad_count = 0;
  int check_count = 0;
  // core clock, 100 ns period
  always #50 clk = ~clk;
  address_translation_unit i_address_translation_unit (
    .CLOCK_IN(clk), .RST_IN(rst), .INSTR_TRANSLATE_ENABLE_IN(ite),
    .DATA_TRANSLATE_ENABLE_IN(dte), .SUPERVISOR_IN(sup), .SEG_WR_IN(seg_wr),
    .SEG_IDX_IN(EA[31:28]), .SEG_DATA_IN(seg_data), .TABLE_BASE_IN(base),
    .TABLE_MASK_IN(mask), .TLB_WR_IN(tlb_wr), .TLB_WR_DATA_IN(tlb_dsel), .TLB_WR_WAY_IN(tlb_way),
    .TLB_WR_ENTRY_IN(tlb_e), .TLB_INV_IN(tlb_inv), .TLB_INV_EA_IN(EA), .BAT_WR_IN(bat_wr),
    .BAT_WR_DATA_IN(bat_dsel), .BAT_WR_IDX_IN(bat_idx), .BAT_WR_ENTRY_IN(bat_e),
    .FETCH_REQ_IN(req[0]), .LSU_REQ_IN(req[1]), .FETCH_RESP_OUT(resp[0]),
    .LSU_RESP_OUT(resp[1]), .FETCH_EXC_OUT(exc[0]), .LSU_EXC_OUT(exc[1]));
  // unit 0 is the fetch side, unit 1 the load/store side
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    access_unit_model i_access_unit_model (.clk_in(clk), .go_in(go[u]), .store_in(st[u]),
      .ea_in(ea[u]), .req_out(req[u]), .resp_in(resp[u]), .exc_in(exc[u]),
      .resp_out(got_r[u]), .exc_out(got_e[u]));
  end
  // inputs move a fixed 10 ns after the rising edge
  task automatic tick();
    @(posedge clk);
    #10;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one request; the answer is captured by the model one cycle later
  task automatic acc(input int u, input logic s, input logic [31:0] a);
    go[u] = 1'b1;
    st[u] = s;
    ea[u] = a;
    tick();
    go[u] = 1'b0;
    tick();
  endtask
  task automatic fault(input int u, input logic [15:0] vec);
    chk("fault ok", got_r[u].ok, 1'b0);
    chk("fault valid", got_e[u].valid, 1'b1);
    chk("fault vector", got_e[u].vector, vec);
  endtask
  task automatic tlb_load(input logic d, input logic w, input logic [1:0] pp, input logic c);
    tlb_dsel = d;
    tlb_way = w;
    tlb_e = '{1'b1, VSID, EA[27:12], RPN, pp, c};
    tlb_wr = 1'b1;
    tick();
    tlb_wr = 1'b0;
    tick();
  endtask
  // segment of the test address, with the user key as given
  task automatic seg_load(input logic k);
    seg_data = '{VSID, 1'b0, k};
    seg_wr = 1'b1;
    tick();
    seg_wr = 1'b0;
  endtask
  // block entry from bat_e into the chosen array and slot
  task automatic bat_load(input logic d, input logic [1:0] i);
    bat_dsel = d;
    bat_idx = i;
    bat_wr = 1'b1;
    tick();
    bat_wr = 1'b0;
    tick();
  endtask
  task automatic t_off();
    for (int u = 0; u < 2; u++)
    begin
      acc(u, 1'(u), EA);
      chk("off pa", got_r[u].pa, EA);
      chk("off ok", got_r[u].ok, 1'b1);
      chk("off exc", got_e[u].valid, 1'b0);
    end
  endtask
  task automatic t_miss();
    logic [18:0] h;
    logic [31:0] g;
    h = VSID[18:0] ^ {3'b0, EA[27:12]};
    g = {base[15:9], base[8:0] | (h[18:10] & mask), h[9:0], 6'h00};
    ite = 1'b1;
    dte = 1'b1;
    acc(0, 1'b0, EA);
    fault(0, 16'h1000);
    chk("assist group", got_e[0].page_entry_group_addr, g);
    chk("assist api", got_e[0].api, EA[27:22]);
    chk("assist vsid", got_e[0].vsid, VSID);
    chk("assist ea", got_e[0].ea, EA);
    acc(1, 1'b0, EA);
    fault(1, 16'h1100);
    acc(1, 1'b1, EA);
    fault(1, 16'h1200);
  endtask
  task automatic t_hit();
    tlb_load(1'b1, 1'b0, 2'b10, 1'b0); // read-write data page, changed clear
    acc(1, 1'b0, EA);
    chk("hit ok", got_r[1].ok, 1'b1);
    chk("hit pa", got_r[1].pa, {RPN, EA[11:0]});
    chk("hit blk", got_r[1].blk, 1'b0);
    chk("hit exc", got_e[1].valid, 1'b0);
    acc(0, 1'b0, EA);
    fault(0, 16'h1000);
    acc(1, 1'b1, EA);
    fault(1, 16'h1200);
  endtask
  task automatic t_inv();
    for (int s = 0; s < 2; s++)
    begin
      sup = 1'(s);
      tlb_inv = 1'b1;
      tick();
      tlb_inv = 1'b0;
      acc(1, 1'b0, EA);
      chk("inv ok", got_r[1].ok, s == 0);
    end
    fault(1, 16'h1100);
  endtask
  task automatic t_bat();
    tlb_load(1'b1, 1'b0, 2'b10, 1'b0);
    bat_e = '{EA[31:17], 11'h000, 1'b1, 1'b1, 15'h4321, 2'b10};
    bat_load(1'b1, 2'h0);
    acc(1, 1'b0, EA);
    chk("block blk", got_r[1].blk, 1'b1);
    chk("block pa", got_r[1].pa, {15'h4321, EA[16:0]});
    acc(1, 1'b0, EA2);
    fault(1, 16'h1100);
    acc(0, 1'b0, EA);
    fault(0, 16'h1000);
    bat_e = '{EA[31:17], 11'h001, 1'b1, 1'b1, 15'h1110, 2'b01};
    bat_load(1'b0, 2'h3);
    acc(0, 1'b0, EA);
    chk("fetch block pa", got_r[0].pa, {15'h1110, EA[16:0]});
    chk("fetch block ok", got_r[0].ok, 1'b1);
    acc(0, 1'b0, EA2);
    chk("wide block pa", got_r[0].pa, {15'h1111, EA[16:0]});
  endtask
  // page protection on both classes, and the replacement way handed to software
  task automatic t_prot();
    tlb_load(1'b1, 1'b0, 2'b11, 1'b1); // read-only data page
    acc(1, 1'b0, EA);
    chk("ro load ok", got_r[1].ok, 1'b1);
    acc(1, 1'b1, EA);
    fault(1, 16'h0300);
    acc(1, 1'b0, EA2);
    fault(1, 16'h1100);
    chk("data assist way", got_e[1].way, 1'b1);
    tlb_load(1'b0, 1'b1, 2'b00, 1'b1); // fetch page, open to key 0 only
    acc(0, 1'b0, EA);
    chk("fetch hit ok", got_r[0].ok, 1'b1);
    chk("fetch hit pa", got_r[0].pa, {RPN, EA[11:0]});
    acc(0, 1'b0, EA2);
    fault(0, 16'h1000);
    chk("fetch assist way", got_e[0].way, 1'b0);
    seg_load(1'b1);
    acc(0, 1'b0, EA);
    fault(0, 16'h0400);
    seg_load(1'b0);
  endtask
  // reset in mid-run: no answer while held, then all state cleared
  task automatic t_reset();
    rst = 1'b1;
    acc(1, 1'b0, EA);
    chk("reset valid", got_r[1].valid, 1'b0);
    chk("reset exc", got_e[1].valid, 1'b0);
    rst = 1'b0;
    tick();
    acc(1, 1'b0, EA);
    fault(1, 16'h1100);
    chk("reset vsid", got_e[1].vsid, 24'h000000);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #10;
    rst = 1'b0;
    tick();
    seg_load(1'b0);
    t_off();
    t_miss();
    t_hit();
    t_prot();
    t_inv();
    t_bat();
    t_reset();
    end_of_test();
  end
  // watchdog, far beyond the seventy or so cycles the tests need
  initial
  begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule // tb_top
